// ===== rtl/sato_top.sv
// Operation
// - Loop open drives DAC from override field
// - Loop-open bit opens PLL; resets closed
// - Pump select picks calibrated or override current
// - Array select picks calibrated or override array
// - Current select picks calibrated or override current
// - Pump disable and forced up/down currents
// - Mixer DC test forces I/Q signs
// - Test module connects to filter or ADC
// - Interface bits drive test module when connected
// - Frequency comparator output when enabled
// - Delta-sigma dither on by default
// - ADC test puts samples on pins
// - Three ADC shaping disable bits
// - Rotation field selects input rotation sequence
`timescale 1ns/100ps
`include "sato_defs.svh"

module sato_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Calibrated values from the synthesizer calibration
  input wire logic [3:0] cal_dac_cal,
  input wire logic [3:0] pump_current_cal,
  input wire logic [4:0] osc_array_cal,
  input wire logic [5:0] osc_current_cal,
  input wire logic osc_cal_comparator,
  // Phase detector and ADC sources
  input wire logic freq_comp,
  input wire logic adc_sample_lock,
  input wire logic adc_sample_data,
  input wire logic adc_clk_level,
  input wire logic adc_rot_step,
  // Normal pin sources
  input wire logic lock_normal,
  input wire logic data_normal,
  input wire logic data_clock_normal,
  // Applied synthesizer settings
  output logic pll_loop_open,
  output logic [3:0] cal_dac_applied,
  output logic [3:0] pump_current_applied,
  output logic [4:0] osc_array_applied,
  output logic [5:0] osc_current_applied,
  output logic osc_cal_clock,
  // Charge pump and mixer test
  output logic pump_disable,
  output logic pump_force_up,
  output logic pump_force_down,
  output logic mixer_dc_test_en,
  output logic mixer_i_pos,
  output logic mixer_q_pos,
  // Analog test module
  output logic filter_test_connect,
  output logic adc_test_connect,
  output logic test_module_powerdown,
  output logic [2:0] test_mode,
  // Synthesizer and ADC test
  output logic freq_comp_out,
  output logic sigma_delta_dither_en,
  output logic integrator_chop_off,
  output logic feedback_shaping_off,
  output logic common_mode_rotation_off,
  output logic [1:0] adc_rotation,
  // Device pins
  output logic lock_pin,
  output logic data_pin,
  output logic data_clock_pin
);

  // Register bank: five test registers and interface register
  logic [7:0] bank_r [0:5];
  // Held write address, data and strobe
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_idx_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  // Read channel
  sato_pkg::sato_rd_state_t rd_state_r;
  // Manual calibration capture
  logic cur_sel_prev_r;
  logic comp_sample_r;
  logic [3:0] sample_cnt_r;
  logic do_write;
  sato_pkg::sato_slot_t wr_slot;
  sato_pkg::sato_slot_t rd_slot;

  // Index to bank slot; shared by both channels
  function automatic sato_pkg::sato_slot_t slot_of(input logic [7:0] idx);
    sato_pkg::sato_slot_t s;
    s = 3'h7;
    if (idx == `SATO_IDX_CAL_DAC) s = 3'h0;
    if (idx == `SATO_IDX_LOOP_VCO) s = 3'h1;
    if (idx == `SATO_IDX_OSC_CUR) s = 3'h2;
    if (idx == `SATO_IDX_PUMP_MIX) s = 3'h3;
    if (idx == `SATO_IDX_ADC_CTL) s = 3'h4;
    if (idx == `SATO_IDX_IFACE) s = 3'h5;
    if (idx == `SATO_IDX_CAL_STAT) s = 3'h6;
    return s;
  endfunction : slot_of

  // Reset value of a bank slot
  function automatic logic [7:0] reset_of(input int slot);
    logic [7:0] v;
    v = `SATO_RST_IFACE;
    if (slot == 0) v = `SATO_RST_CAL_DAC;
    if (slot == 1) v = `SATO_RST_LOOP_VCO;
    if (slot == 2) v = `SATO_RST_OSC_CUR;
    if (slot == 3) v = `SATO_RST_PUMP_MIX;
    if (slot == 4) v = `SATO_RST_ADC_CTL;
    return v;
  endfunction : reset_of

  // Field taps from the bank
  logic loop_open;
  logic cur_sel;
  logic manual_osc_cal_en;
  logic [1:0] mixer_dc_code;
  logic test_linked;
  assign loop_open = bank_r[1][`SATO_F_LOOP_OPEN];
  assign cur_sel = bank_r[2][`SATO_F_CUR_SEL];
  assign manual_osc_cal_en = bank_r[2][`SATO_F_MAN_CAL];
  assign mixer_dc_code = bank_r[3][`SATO_F_MIX_MSB:`SATO_F_MIX_LSB];
  assign test_linked = bank_r[3][`SATO_F_FILT_CON] |
                       bank_r[3][`SATO_F_ADC_CON];

  // Bus handshakes; a channel stalls while its item is held
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = (rd_state_r == sato_pkg::SATO_RD_IDLE);
  assign do_write = aw_held_r && w_held_r;
  assign wr_slot = slot_of(aw_idx_r);
  assign rd_slot = slot_of(s_axi_araddr[9:2]);

  // Capture write address, either order with data
  always_ff @(posedge core_clk) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      aw_idx_r <= 8'h00;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_idx_r <= s_axi_awaddr[9:2];
    end
  end

  // Capture write data; only the low lane carries bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      w_held_r <= 1'b0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata[7:0];
      wstrb0_r <= s_axi_wstrb[0];
    end
  end

  // Write response; status and unmapped answer with an error
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SATO_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_slot > 3'h5) ? `SATO_RESP_SLVERR
                                      : `SATO_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Bank storage, one generated register per slot
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gen_bank
      always_ff @(posedge core_clk) begin
        if (reset) begin
          bank_r[g] <= reset_of(g);
        end else if (do_write && wstrb0_r &&
                     wr_slot == 3'(g)) begin
          bank_r[g] <= wdata_r;
        end
      end
    end
  endgenerate

  // Read channel; data registered, upper bits zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_state_r <= sato_pkg::SATO_RD_IDLE;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SATO_RESP_OKAY;
    end else begin
      unique case (rd_state_r)
        sato_pkg::SATO_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_r <= sato_pkg::SATO_RD_DATA;
            s_axi_rresp <= `SATO_RESP_OKAY;
            if (rd_slot < 3'h6) begin
              s_axi_rdata <= {24'h000000, bank_r[rd_slot]};
            end else if (rd_slot == 3'h6) begin
              s_axi_rdata <= {24'h000000, sample_cnt_r, 3'h0,
                              comp_sample_r};
            end else begin
              // Unmapped address reads zero with an error
              s_axi_rdata <= 32'h00000000;
              s_axi_rresp <= `SATO_RESP_SLVERR;
            end
          end
        end
        sato_pkg::SATO_RD_DATA: begin
          if (s_axi_rready) begin
            rd_state_r <= sato_pkg::SATO_RD_IDLE;
          end
        end
      endcase
    end
  end
  assign s_axi_rvalid = (rd_state_r == sato_pkg::SATO_RD_DATA);

  // Synthesizer overrides, registered so outputs never glitch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pll_loop_open <= 1'b0;
      cal_dac_applied <= 4'h0;
      pump_current_applied <= 4'h0;
      osc_array_applied <= 5'h00;
      osc_current_applied <= 6'h00;
    end else begin
      pll_loop_open <= loop_open;
      cal_dac_applied <= loop_open ?
        bank_r[0][`SATO_F_DAC_MSB:`SATO_F_DAC_LSB] : cal_dac_cal;
      pump_current_applied <= bank_r[1][`SATO_F_PCUR_SEL] ?
        bank_r[0][`SATO_F_PCUR_MSB:`SATO_F_PCUR_LSB] :
        pump_current_cal;
      osc_array_applied <= bank_r[1][`SATO_F_ARR_SEL] ?
        bank_r[1][`SATO_F_ARR_MSB:`SATO_F_ARR_LSB] :
        osc_array_cal;
      osc_current_applied <= cur_sel ?
        bank_r[2][`SATO_F_CUR_MSB:`SATO_F_CUR_LSB] :
        osc_current_cal;
    end
  end

  // Manual calibration clock follows the select bit while the manual calibration enable is set
  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_cal_clock <= 1'b0;
      cur_sel_prev_r <= 1'b0;
    end else begin
      osc_cal_clock <= manual_osc_cal_en && cur_sel;
      cur_sel_prev_r <= cur_sel;
    end
  end

  // Falling select samples the comparator; count wraps at 16
  always_ff @(posedge core_clk) begin
    if (reset) begin
      comp_sample_r <= 1'b0;
      sample_cnt_r <= 4'h0;
    end else if (manual_osc_cal_en && cur_sel_prev_r && !cur_sel) begin
      comp_sample_r <= osc_cal_comparator;
      sample_cnt_r <= sample_cnt_r + 4'h1;
    end
  end

  // Pump and mixer forcing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pump_disable <= 1'b0;
      pump_force_up <= 1'b0;
      pump_force_down <= 1'b0;
      mixer_dc_test_en <= 1'b0;
      mixer_i_pos <= 1'b0;
      mixer_q_pos <= 1'b0;
    end else begin
      pump_disable <= bank_r[3][`SATO_F_PUMP_DIS];
      pump_force_up <= bank_r[3][`SATO_F_PUMP_UP];
      pump_force_down <= bank_r[3][`SATO_F_PUMP_DN];
      mixer_dc_test_en <= bank_r[3][`SATO_F_MIX_EN];
      // Code bit 1 is the I sign, bit 0 the Q sign
      mixer_i_pos <= bank_r[3][`SATO_F_MIX_EN] & mixer_dc_code[1];
      mixer_q_pos <= bank_r[3][`SATO_F_MIX_EN] & mixer_dc_code[0];
    end
  end

  // Analog test module routing and control
  always_ff @(posedge core_clk) begin
    if (reset) begin
      filter_test_connect <= 1'b0;
      adc_test_connect <= 1'b0;
      test_module_powerdown <= 1'b1;
      test_mode <= 3'h4;
    end else begin
      filter_test_connect <= bank_r[3][`SATO_F_FILT_CON];
      adc_test_connect <= bank_r[3][`SATO_F_ADC_CON];
      if (test_linked) begin
        test_module_powerdown <= bank_r[5][`SATO_F_TPD];
        test_mode <= bank_r[5][`SATO_F_TMODE_MSB:`SATO_F_TMODE_LSB];
      end else begin
        // Unconnected module kept powered down
        test_module_powerdown <= 1'b1;
        test_mode <= {1'b1,
          bank_r[5][`SATO_F_TMODE_MSB-1:`SATO_F_TMODE_LSB]};
      end
    end
  end

  // Synthesizer and ADC option outputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      freq_comp_out <= 1'b0;
      sigma_delta_dither_en <= 1'b1;
      integrator_chop_off <= 1'b0;
      feedback_shaping_off <= 1'b0;
      common_mode_rotation_off <= 1'b0;
    end else begin
      freq_comp_out <= bank_r[4][`SATO_F_FCOMP_EN] & freq_comp;
      sigma_delta_dither_en <= bank_r[4][`SATO_F_DITHER];
      integrator_chop_off <= bank_r[4][`SATO_F_CHOP_OFF];
      feedback_shaping_off <= bank_r[4][`SATO_F_SHAPE_OFF];
      common_mode_rotation_off <= bank_r[4][`SATO_F_VCM_OFF];
    end
  end

  // Pin multiplexing for ADC test output
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_pin <= 1'b0;
      data_pin <= 1'b0;
      data_clock_pin <= 1'b0;
    end else if (bank_r[4][`SATO_F_ADC_OUT]) begin
      lock_pin <= adc_sample_lock;
      data_pin <= adc_sample_data;
      data_clock_pin <= adc_clk_level;
    end else begin
      lock_pin <= lock_normal;
      data_pin <= data_normal;
      data_clock_pin <= data_clock_normal;
    end
  end

  // Input rotation sequencer
  sato_rotate u_rotate (
    .core_clk(core_clk),
    .reset(reset),
    .step(adc_rot_step),
    .mode(bank_r[4][`SATO_F_ROT_MSB:`SATO_F_ROT_LSB]),
    .pos(adc_rotation)
  );

  // Checks
  chk_dac_override: assert property (@(posedge core_clk) disable iff (reset)
    loop_open |=> cal_dac_applied ==
      $past(bank_r[0][`SATO_F_DAC_MSB:`SATO_F_DAC_LSB]))
    else $error("DAC override not applied");

  chk_loop_state: assert property (@(posedge core_clk) disable iff (reset)
    $rose(loop_open) |=> pll_loop_open ##1 pll_loop_open || !loop_open)
    else $error("Loop open not followed");

  chk_pump_current: assert property (@(posedge core_clk) disable iff (reset)
    !bank_r[1][`SATO_F_PCUR_SEL] |=>
      pump_current_applied == $past(pump_current_cal))
    else $error("Calibrated pump current not used");

  chk_array_override: assert property (@(posedge core_clk) disable iff (reset)
    bank_r[1][`SATO_F_ARR_SEL] |=> osc_array_applied ==
      $past(bank_r[1][`SATO_F_ARR_MSB:`SATO_F_ARR_LSB]))
    else $error("Array override not applied");

  chk_current_select: assert property (@(posedge core_clk) disable iff (reset)
    !cur_sel |=> osc_current_applied == $past(osc_current_cal))
    else $error("Calibrated current not used");

  chk_cal_sample: assert property (@(posedge core_clk) disable iff (reset)
    manual_osc_cal_en && $fell(cur_sel) |=>
      sample_cnt_r == $past(sample_cnt_r) + 4'h1)
    else $error("Falling select did not sample");

  chk_mixer_code: assert property (@(posedge core_clk) disable iff (reset)
    bank_r[3][`SATO_F_MIX_EN] |=>
      {mixer_i_pos, mixer_q_pos} == $past(mixer_dc_code))
    else $error("Mixer code not forced");

  chk_test_park: assert property (@(posedge core_clk) disable iff (reset)
    !test_linked |=> test_module_powerdown && test_mode[2])
    else $error("Test module not parked");

  chk_adc_pins: assert property (@(posedge core_clk) disable iff (reset)
    bank_r[4][`SATO_F_ADC_OUT] |=> data_clock_pin == $past(adc_clk_level)
      && data_pin == $past(adc_sample_data)
      && lock_pin == $past(adc_sample_lock))
    else $error("ADC test pins wrong");

  chk_write_resp: assert property (@(posedge core_clk) disable iff (reset)
    do_write |=> s_axi_bvalid && !aw_held_r && !w_held_r)
    else $error("Write response missing");

endmodule : sato_top

// ===== rtl/sato_defs.svh
`ifndef SATO_DEFS_SVH
`define SATO_DEFS_SVH

// Register indices; byte address is four times the index
`define SATO_IDX_CAL_DAC 8'h21
`define SATO_IDX_LOOP_VCO 8'h22
`define SATO_IDX_OSC_CUR 8'h23
`define SATO_IDX_PUMP_MIX 8'h24
`define SATO_IDX_ADC_CTL 8'h25
`define SATO_IDX_IFACE 8'h30
`define SATO_IDX_CAL_STAT 8'h31

// Reset values of the writable registers
`define SATO_RST_CAL_DAC 8'h4D
`define SATO_RST_LOOP_VCO 8'h10
`define SATO_RST_OSC_CUR 8'h06
`define SATO_RST_PUMP_MIX 8'h00
`define SATO_RST_ADC_CTL 8'h40
`define SATO_RST_IFACE 8'h00

// Field positions, calibration DAC and pump register
`define SATO_F_DAC_MSB 7
`define SATO_F_DAC_LSB 4
`define SATO_F_PCUR_MSB 3
`define SATO_F_PCUR_LSB 0
// Loop and oscillator array register
`define SATO_F_LOOP_OPEN 7
`define SATO_F_PCUR_SEL 6
`define SATO_F_ARR_SEL 5
`define SATO_F_ARR_MSB 4
`define SATO_F_ARR_LSB 0
// Oscillator current register
`define SATO_F_MAN_CAL 7
`define SATO_F_CUR_SEL 6
`define SATO_F_CUR_MSB 5
`define SATO_F_CUR_LSB 0
// Pump and mixer test register
`define SATO_F_PUMP_DIS 7
`define SATO_F_PUMP_UP 6
`define SATO_F_PUMP_DN 5
`define SATO_F_MIX_MSB 4
`define SATO_F_MIX_LSB 3
`define SATO_F_MIX_EN 2
`define SATO_F_FILT_CON 1
`define SATO_F_ADC_CON 0
// ADC and synthesizer test register
`define SATO_F_FCOMP_EN 7
`define SATO_F_DITHER 6
`define SATO_F_ADC_OUT 5
`define SATO_F_CHOP_OFF 4
`define SATO_F_SHAPE_OFF 3
`define SATO_F_VCM_OFF 2
`define SATO_F_ROT_MSB 1
`define SATO_F_ROT_LSB 0
// Interface register test module bits
`define SATO_F_TPD 3
`define SATO_F_TMODE_MSB 2
`define SATO_F_TMODE_LSB 0

// Bus responses
`define SATO_RESP_OKAY 2'b00
`define SATO_RESP_SLVERR 2'b10

`endif

// ===== rtl/sato_pkg.sv
package sato_pkg;
  // Read channel state, one-hot
  typedef enum logic [1:0] {
    SATO_RD_IDLE = 2'b01,
    SATO_RD_DATA = 2'b10
  } sato_rd_state_t;
  // Bank slot number; 6 is status, 7 unmapped
  typedef logic [2:0] sato_slot_t;
endpackage : sato_pkg

// ===== rtl/sato_rotate.sv
`timescale 1ns/100ps
`include "sato_defs.svh"

module sato_rotate (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic step,
  input wire logic [1:0] mode,
  // Rotation position
  output logic [1:0] pos
);

  // Step counter; kept across mode changes
  logic [1:0] idx_r;

  // Position for a mode and step
  function automatic logic [1:0] rot_code(input logic [1:0] m,
                                          input logic [1:0] i);
    logic [1:0] c;
    c = 2'h0;
    unique case (m)
      2'h0: c = i;
      2'h1: c = (i == 2'h0) ? 2'h0 : (i == 2'h1) ? 2'h2 :
                (i == 2'h2) ? 2'h3 : 2'h1;
      2'h2: c = 2'h0;
      2'h3: c = i[0] ? 2'h2 : 2'h0;
    endcase
    return c;
  endfunction : rot_code

  // Advance on each ADC step
  always_ff @(posedge core_clk) begin
    if (reset) begin
      idx_r <= 2'h0;
    end else if (step) begin
      idx_r <= idx_r + 2'h1;
    end
  end

  // Registered position, sequence by mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pos <= 2'h0;
    end else begin
      pos <= rot_code(mode, idx_r);
    end
  end

endmodule : sato_rotate

// ===== test/sato_top_tb.sv
`timescale 1ns/100ps
`include "sato_defs.svh"

module sato_top_tb;
  // Clock, reset and bus
  logic core_clk, reset;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  // Calibrated values and analog sources
  logic [3:0] cal_dac_cal, pump_current_cal;
  logic [4:0] osc_array_cal;
  logic [5:0] osc_current_cal;
  logic osc_cal_comparator, freq_comp, adc_sample_lock, adc_sample_data;
  logic adc_clk_level, adc_rot_step, lock_normal, data_normal;
  logic data_clock_normal;
  // Applied outputs
  logic pll_loop_open, osc_cal_clock, pump_disable, pump_force_up;
  logic [3:0] cal_dac_applied, pump_current_applied;
  logic [4:0] osc_array_applied;
  logic [5:0] osc_current_applied;
  logic pump_force_down, mixer_dc_test_en, mixer_i_pos, mixer_q_pos;
  logic filter_test_connect, adc_test_connect, test_module_powerdown;
  logic [2:0] test_mode;
  logic freq_comp_out, sigma_delta_dither_en, integrator_chop_off;
  logic feedback_shaping_off, common_mode_rotation_off;
  logic [1:0] adc_rotation;
  logic lock_pin, data_pin, data_clock_pin;
  // Bookkeeping
  int mismatches, num_checks, cycles;
  logic [1:0] steps;
  logic [7:0] v;
  logic cn;

  sato_top u_sato_top (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cal_dac_cal, .pump_current_cal,
    .osc_array_cal, .osc_current_cal, .osc_cal_comparator, .freq_comp,
    .adc_sample_lock, .adc_sample_data, .adc_clk_level, .adc_rot_step,
    .lock_normal, .data_normal, .data_clock_normal, .pll_loop_open,
    .cal_dac_applied, .pump_current_applied, .osc_array_applied,
    .osc_current_applied, .osc_cal_clock, .pump_disable, .pump_force_up,
    .pump_force_down, .mixer_dc_test_en, .mixer_i_pos, .mixer_q_pos,
    .filter_test_connect, .adc_test_connect, .test_module_powerdown,
    .test_mode, .freq_comp_out, .sigma_delta_dither_en,
    .integrator_chop_off, .feedback_shaping_off, .common_mode_rotation_off,
    .adc_rotation, .lock_pin, .data_pin, .data_clock_pin);

  // Free-running clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Closing report, the single exit of the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // Hang guard, well above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  // Compare of bus words and responses
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t word got %h want %h", $time, got, exp);
    end
  endtask : chk_word

  // Compare of applied outputs
  task automatic chk_sig(input logic [5:0] got, input logic [5:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t output got %h want %h", $time, got, exp);
    end
  endtask : chk_sig

  // Write; readiness is looked at mid-cycle, release after the edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] val,
      input logic [3:0] strb, input logic [1:0] exp);
    logic ta, tw, tb;
    logic [1:0] resp;
    ta = 1'b0;
    tw = 1'b0;
    tb = 1'b0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, val};
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge core_clk);
      if (s_axi_awvalid && s_axi_awready) ta = 1'b1;
      if (s_axi_wvalid && s_axi_wready) tw = 1'b1;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    while (!tb) begin
      @(negedge core_clk);
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
    end
    s_axi_bready <= 1'b0;
    chk_word({30'h0, resp}, {30'h0, exp});
  endtask : wr

  // Read and compare data and response
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
      input logic [1:0] expr);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] resp;
    ta = 1'b0;
    tr = 1'b0;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!ta) begin
      @(negedge core_clk);
      ta = s_axi_arready;
      @(posedge core_clk);
    end
    s_axi_arvalid <= 1'b0;
    while (!tr) begin
      @(negedge core_clk);
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
    end
    s_axi_rready <= 1'b0;
    chk_word(d, {24'h000000, exp});
    chk_word({30'h0, resp}, {30'h0, expr});
  endtask : rd

  // Let the registered outputs follow a finished write
  task automatic settle();
    repeat (2) @(posedge core_clk);
  endtask : settle

  // Expected rotation position for a mode and a step index
  function automatic logic [1:0] rot_exp(input logic [1:0] m,
      input logic [1:0] i);
    case (m)
      2'h0: rot_exp = i;
      2'h1: rot_exp = (i == 2'h0) ? 2'h0 : (i == 2'h1) ? 2'h2 :
        (i == 2'h2) ? 2'h3 : 2'h1;
      2'h2: rot_exp = 2'h0;
      default: rot_exp = i[0] ? 2'h2 : 2'h0;
    endcase
  endfunction : rot_exp

  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, adc_rot_step, osc_cal_comparator} = '0;
    {cal_dac_cal, pump_current_cal} = 8'hA3;
    osc_array_cal = 5'h05;
    osc_current_cal = 6'h2A;
    {freq_comp, adc_sample_lock, adc_sample_data, adc_clk_level} = 4'hB;
    {lock_normal, data_normal, data_clock_normal} = 3'h2;
    mismatches = 0;
    num_checks = 0;
    cycles = 0;
    steps = 2'h0;
    reset = 1'b1;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    settle();
    // Reset state of bank and outputs
    rd(`SATO_IDX_CAL_DAC, `SATO_RST_CAL_DAC, `SATO_RESP_OKAY);
    rd(`SATO_IDX_LOOP_VCO, 8'h10, `SATO_RESP_OKAY);
    rd(`SATO_IDX_OSC_CUR, 8'h06, `SATO_RESP_OKAY);
    rd(`SATO_IDX_ADC_CTL, 8'h40, `SATO_RESP_OKAY);
    chk_sig(6'(pll_loop_open), 6'h00);
    chk_sig(6'(cal_dac_applied), 6'h0A);
    chk_sig(6'(pump_current_applied), 6'h03);
    chk_sig(6'(osc_array_applied), 6'h05);
    chk_sig(6'(osc_current_applied), 6'h2A);
    chk_sig(6'(sigma_delta_dither_en), 6'h01);
    chk_sig(6'({test_module_powerdown, test_mode}), 6'h0C);
    // Overrides on, reset DAC and pump values, written array value
    wr(`SATO_IDX_LOOP_VCO, 8'hF3, 4'hF, `SATO_RESP_OKAY);
    settle();
    chk_sig(6'(pll_loop_open), 6'h01);
    chk_sig(6'(cal_dac_applied), 6'h04);
    chk_sig(6'(pump_current_applied), 6'h0D);
    chk_sig(6'(osc_array_applied), 6'h13);
    wr(`SATO_IDX_CAL_DAC, 8'h92, 4'hF, `SATO_RESP_OKAY);
    settle();
    chk_sig(6'(cal_dac_applied), 6'h09);
    chk_sig(6'(pump_current_applied), 6'h02);
    rd(`SATO_IDX_LOOP_VCO, 8'hF3, `SATO_RESP_OKAY);
    wr(`SATO_IDX_OSC_CUR, 8'h7F, 4'hF, `SATO_RESP_OKAY);
    settle();
    chk_sig(osc_current_applied, 6'h3F);
    chk_sig(6'(osc_cal_clock), 6'h00);
    // Manual calibration: falling select bit samples the comparator
    osc_cal_comparator <= 1'b1;
    wr(`SATO_IDX_OSC_CUR, 8'hC1, 4'hF, `SATO_RESP_OKAY);
    settle();
    chk_sig(6'(osc_cal_clock), 6'h01);
    wr(`SATO_IDX_OSC_CUR, 8'h81, 4'hF, `SATO_RESP_OKAY);
    settle();
    chk_sig(6'(osc_cal_clock), 6'h00);
    chk_sig(osc_current_applied, 6'h2A);
    rd(`SATO_IDX_CAL_STAT, 8'h11, `SATO_RESP_OKAY);
    // Pump, mixer codes and test module routing
    wr(`SATO_IDX_IFACE, 8'h03, 4'hF, `SATO_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      v = {1'b1, k[0], ~k[0], k[1:0], 1'b1, k[1], k[0]};
      cn = (k != 0);
      wr(`SATO_IDX_PUMP_MIX, v, 4'hF, `SATO_RESP_OKAY);
      settle();
      chk_sig(6'({pump_disable, pump_force_up, pump_force_down}),
        6'({1'b1, k[0], ~k[0]}));
      chk_sig(6'({mixer_dc_test_en, mixer_i_pos, mixer_q_pos}),
        6'({1'b1, k[1:0]}));
      chk_sig(6'({filter_test_connect, adc_test_connect}),
        6'(k[1:0]));
      chk_sig(6'({test_module_powerdown, test_mode}),
        cn ? 6'h03 : 6'h0F);
      rd(`SATO_IDX_PUMP_MIX, v, `SATO_RESP_OKAY);
    end
    // Comparator, pin routing and shaping controls
    for (int k = 0; k < 2; k++) begin
      v = k[0] ? 8'hBC : 8'h40;
      wr(`SATO_IDX_ADC_CTL, v, 4'hF, `SATO_RESP_OKAY);
      settle();
      chk_sig(6'({freq_comp_out, sigma_delta_dither_en}),
        6'(v[7:6]));
      chk_sig(6'({integrator_chop_off, feedback_shaping_off,
        common_mode_rotation_off}), 6'(v[4:2]));
      chk_sig(6'({lock_pin, data_pin, data_clock_pin}),
        v[5] ? 6'h03 : 6'h02);
    end
    // Comparator output follows live freq_comp with the enable set, pins follow live ADC sources
    freq_comp <= 1'b0;
    {adc_sample_lock, adc_sample_data, adc_clk_level} <= 3'h4;
    settle();
    chk_sig(6'(freq_comp_out), 6'h00);
    chk_sig(6'({lock_pin, data_pin, data_clock_pin}), 6'h04);
    // Rotation sequences for every mode
    for (int m = 0; m < 4; m++) begin
      wr(`SATO_IDX_ADC_CTL, {6'h10, m[1:0]}, 4'hF, `SATO_RESP_OKAY);
      settle();
      chk_sig(6'(adc_rotation), 6'(rot_exp(m[1:0], steps)));
      repeat (4) begin
        @(posedge core_clk);
        adc_rot_step <= 1'b1;
        @(posedge core_clk);
        adc_rot_step <= 1'b0;
        steps = steps + 2'h1;
        settle();
        chk_sig(6'(adc_rotation), 6'(rot_exp(m[1:0], steps)));
      end
    end
    // Refused accesses and a write with no strobe leave the bank untouched
    wr(8'h26, 8'h55, 4'hF, `SATO_RESP_SLVERR);
    rd(8'h26, 8'h00, `SATO_RESP_SLVERR);
    wr(`SATO_IDX_CAL_STAT, 8'hFF, 4'hF, `SATO_RESP_SLVERR);
    rd(`SATO_IDX_CAL_STAT, 8'h11, `SATO_RESP_OKAY);
    wr(`SATO_IDX_CAL_DAC, 8'h00, 4'h0, `SATO_RESP_OKAY);
    rd(`SATO_IDX_CAL_DAC, 8'h92, `SATO_RESP_OKAY);
    stop_test();
  end
endmodule : sato_top_tb
